// File: pkg/seq_pkg.sv
// shared constants and types for the program sequencer
`default_nettype none
package seq_pkg;

  // program counter and program memory word
  localparam int unsigned PC_W        = 11;
  localparam int unsigned WORD_W      = 14;
  localparam int unsigned PHASE_W     = 2;

  // four system clocks make one instruction cycle
  localparam logic [PHASE_W-1:0] PHASE_LAST = 2'h3;

  // data memory offsets of the sequencer registers
  localparam logic [6:0] PC_LOW_ADDR   = 7'h06;
  localparam logic [6:0] TAB_PTR_ADDR  = 7'h07;
  localparam logic [6:0] TAB_HIGH_ADDR = 7'h08;

  // reset values
  localparam logic [PC_W-1:0] PC_RESET   = 11'h000;
  localparam logic [7:0]      TAB_PTR_RESET  = 8'h00;
  localparam logic [5:0]      TAB_HIGH_RESET = 6'h00;

  // interrupt vectors
  localparam logic [PC_W-1:0] VEC_EXT   = 11'h004;
  localparam logic [PC_W-1:0] VEC_TIMER = 11'h008;
  localparam logic [PC_W-1:0] VEC_ADC   = 11'h00c;

  // what the decoder asks of the sequencer for one instruction
  typedef enum logic [2:0] {
    CMD_NONE     = 3'b000,
    CMD_JUMP     = 3'b001,
    CMD_CALL     = 3'b010,
    CMD_RET      = 3'b011,
    CMD_SKIP     = 3'b100,
    CMD_TAB_CUR  = 3'b101,
    CMD_TAB_LAST = 3'b110
  } cmd_kind_t;

  typedef struct packed {
    cmd_kind_t       kind;
    logic [PC_W-1:0] target;  // address field of jump or call
  } seq_cmd_t;

  // interrupt requests already gated by their own enables
  typedef struct packed {
    logic ext;
    logic timer;
    logic adc;
  } irq_t;

  // sequencer state
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_TABLE = 2'b01
  } seq_state_t;

endpackage : seq_pkg
`default_nettype wire

// File: hw/program_sequencer_table_read.sv
// instruction sequencer with program counter and table read
`timescale 1ns/10ps
`default_nettype none

module program_sequencer_table_read
  import seq_pkg::*;
#(
  parameter bit SMALL_ROM = 1'b0
) (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // program memory
  output logic     [PC_W-1:0]    pm_addr,
  input  wire logic [WORD_W-1:0] pm_data,
  // instruction handed to the decoder
  output logic     [PHASE_W-1:0] phase,
  output logic     [WORD_W-1:0]  instr,
  output logic                   instr_valid,
  input  wire seq_cmd_t          cmd,
  // return stack
  input  wire logic [PC_W-1:0]   stack_top,
  input  wire logic              stack_full,
  output logic                   push,
  output logic                   pop,
  output logic     [PC_W-1:0]    push_addr,
  // interrupts
  input  wire irq_t              irq,
  output irq_t                   irq_ack,
  // data memory side of the registers
  input  wire logic [6:0]        dm_addr,
  input  wire logic              dm_wr,
  input  wire logic [7:0]        dm_wdata,
  output logic     [7:0]         dm_rdata,
  // low byte of a table word for the destination
  output logic     [7:0]         tab_low,
  output logic                   tab_low_wr
);

  // mask removes the top counter bit on the small part
  localparam logic [PC_W-1:0] PC_MASK_BIG   = 11'h7ff;
  localparam logic [PC_W-1:0] PC_MASK_SMALL = 11'h3ff;
  localparam logic [PC_W-1:0] PC_ONE        = 11'h001;
  localparam logic [PC_W-1:0] PC_MASK =
    SMALL_ROM ? PC_MASK_SMALL : PC_MASK_BIG;

  logic [PHASE_W-1:0] phase_q;
  logic [PC_W-1:0]    pc_q;
  logic [PC_W-1:0]    pc_d;
  logic [PC_W-1:0]    pm_addr_q;
  logic [WORD_W-1:0]  ir_q;
  logic               ir_valid_q;
  logic               ir_valid_d;
  logic               instr_valid_q;
  seq_state_t         state_q;
  seq_state_t         state_d;
  logic [7:0]         tab_ptr_q;
  logic [5:0]         tab_high_q;
  logic [7:0]         rdata_q;
  logic [7:0]         tab_low_q;
  logic               tab_low_wr_q;
  logic               push_q;
  logic               pop_q;
  logic [PC_W-1:0]    push_addr_q;
  irq_t               irq_ack_q;
  irq_t               irq_ack_d;
  logic               cyc_end;
  logic               exec;
  logic               pc_low_wr;
  logic               irq_take;
  logic [PC_W-1:0]    irq_vec;
  logic [PC_W-1:0]    ret_addr;
  logic [PC_W-1:0]    tab_addr;
  logic [PC_W-1:0]    fetch_d;

  // phase counter: one instruction cycle every four clocks
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phase_q <= '0;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end

  assign cyc_end = (phase_q == PHASE_LAST);

  // instruction in the register is executed this cycle
  assign exec   = ir_valid_q && (state_q == ST_RUN);
  assign pc_low_wr = exec && dm_wr && (dm_addr == PC_LOW_ADDR);

  // counter already points at the fetched word, the return address
  assign ret_addr = pc_q;

  // table address from pointer and page
  always_comb begin
    tab_addr = {pc_q[PC_W-1:8], tab_ptr_q};
    if (cmd.kind == CMD_TAB_LAST) begin
      tab_addr = {PC_MASK[PC_W-1:8], tab_ptr_q};
    end
    tab_addr = tab_addr & PC_MASK;
  end

  // interrupt priority, held off while the stack is full
  always_comb begin
    irq_ack_d = '0;
    irq_vec   = VEC_EXT;
    if (irq.ext) begin
      irq_ack_d.ext = 1'b1;
      irq_vec       = VEC_EXT;
    end else if (irq.timer) begin
      irq_ack_d.timer = 1'b1;
      irq_vec         = VEC_TIMER;
    end else if (irq.adc) begin
      irq_ack_d.adc = 1'b1;
      irq_vec       = VEC_ADC;
    end
  end

  // interrupt taken only between plain instructions
  always_comb begin
    irq_take = 1'b0;
    if (exec && !stack_full && (irq.ext || irq.timer || irq.adc)) begin
      irq_take = (cmd.kind == CMD_NONE) && !pc_low_wr;
    end
  end

  // next counter, next fetch address and pipeline validity
  always_comb begin
    pc_d       = (pc_q + PC_ONE) & PC_MASK;
    fetch_d    = pc_d;
    ir_valid_d = 1'b1;
    state_d    = ST_RUN;
    if (state_q == ST_TABLE) begin
      // dummy cycle read the table; resume with held word
      pc_d       = pc_q;
      fetch_d    = pc_q;
      ir_valid_d = ir_valid_q;
    end else if (irq_take) begin
      pc_d       = irq_vec;
      fetch_d    = irq_vec;
      ir_valid_d = 1'b0;
    end else if (pc_low_wr) begin
      pc_d       = {pc_q[PC_W-1:8], dm_wdata} & PC_MASK;
      fetch_d    = pc_d;
      ir_valid_d = 1'b0;
    end else if (exec) begin
      unique case (cmd.kind)
        CMD_JUMP, CMD_CALL: begin
          pc_d       = cmd.target & PC_MASK;
          fetch_d    = pc_d;
          ir_valid_d = 1'b0;
        end
        CMD_RET: begin
          pc_d       = stack_top & PC_MASK;
          fetch_d    = pc_d;
          ir_valid_d = 1'b0;
        end
        CMD_SKIP: begin
          // fetched word dropped, next fetch is skip address + 2
          pc_d       = (pc_q + PC_ONE) & PC_MASK;
          fetch_d    = pc_d;
          ir_valid_d = 1'b0;
        end
        CMD_TAB_CUR, CMD_TAB_LAST: begin
          // next word fetched now, table word read next cycle
          pc_d       = (pc_q + PC_ONE) & PC_MASK;
          fetch_d    = tab_addr;
          ir_valid_d = 1'b1;
          state_d    = ST_TABLE;
        end
        CMD_NONE: begin
          pc_d       = (pc_q + PC_ONE) & PC_MASK;
          fetch_d    = pc_d;
        end
        default: begin
          pc_d       = (pc_q + PC_ONE) & PC_MASK;
          fetch_d    = pc_d;
        end
      endcase
    end
  end

  // program counter and fetch address
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pc_q      <= PC_RESET;
      pm_addr_q <= PC_RESET;
    end else if (cyc_end) begin
      pc_q      <= pc_d;
      pm_addr_q <= (state_q == ST_TABLE) ? pc_q : fetch_d;
    end
  end

  // instruction register: fetched word drops into it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ir_q       <= '0;
      ir_valid_q <= 1'b0;
    end else if (cyc_end) begin
      if (state_q != ST_TABLE) begin
        ir_q <= pm_data;
      end
      ir_valid_q <= ir_valid_d;
    end
  end

  // sequencer state
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q       <= ST_RUN;
      instr_valid_q <= 1'b0;
    end else if (cyc_end) begin
      state_q       <= state_d;
      instr_valid_q <= ir_valid_d && (state_d == ST_RUN);
    end
  end

  // table pointer written from the data side
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tab_ptr_q <= TAB_PTR_RESET;
    end else if (cyc_end && exec && dm_wr && dm_addr == TAB_PTR_ADDR) begin
      tab_ptr_q <= dm_wdata;
    end
  end

  // table word capture; high byte written only by table reads
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tab_high_q   <= TAB_HIGH_RESET;
      tab_low_q    <= '0;
      tab_low_wr_q <= 1'b0;
    end else begin
      tab_low_wr_q <= 1'b0;
      if (cyc_end && state_q == ST_TABLE) begin
        tab_low_q    <= pm_data[7:0];
        tab_high_q   <= pm_data[WORD_W-1:8];
        tab_low_wr_q <= 1'b1;
      end
    end
  end

  // stack and interrupt handshakes, one clock each
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      push_q      <= 1'b0;
      pop_q       <= 1'b0;
      push_addr_q <= '0;
      irq_ack_q   <= '0;
    end else begin
      push_q    <= 1'b0;
      pop_q     <= 1'b0;
      irq_ack_q <= '0;
      if (cyc_end && irq_take) begin
        push_q      <= 1'b1;
        push_addr_q <= ret_addr;
        irq_ack_q   <= irq_ack_d;
      end else if (cyc_end && exec && !pc_low_wr) begin
        if (cmd.kind == CMD_CALL) begin
          push_q      <= 1'b1;
          push_addr_q <= ret_addr;
        end
        if (cmd.kind == CMD_RET) begin
          pop_q <= 1'b1;
        end
      end
    end
  end

  // register read port; high byte top bits read zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_q <= '0;
    end else begin
      unique case (dm_addr)
        PC_LOW_ADDR:   rdata_q <= pc_q[7:0];
        TAB_PTR_ADDR:  rdata_q <= tab_ptr_q;
        TAB_HIGH_ADDR: rdata_q <= {2'b00, tab_high_q};
        default:       rdata_q <= '0;
      endcase
    end
  end

  // outputs straight from flip-flops
  assign pm_addr     = pm_addr_q;
  assign phase       = phase_q;
  assign instr       = ir_q;
  assign instr_valid = instr_valid_q;
  assign push        = push_q;
  assign pop         = pop_q;
  assign push_addr   = push_addr_q;
  assign irq_ack     = irq_ack_q;
  assign dm_rdata    = rdata_q;
  assign tab_low     = tab_low_q;
  assign tab_low_wr  = tab_low_wr_q;

endmodule : program_sequencer_table_read

`default_nettype wire

// File: bench/seq_sva.sv
// assertions on the sequencer ports
`timescale 1ns/10ps
`default_nettype none
module seq_sva
  import seq_pkg::*;
(
  input wire logic               clk_sys,
  input wire logic               rst,
  input wire logic [PC_W-1:0]    pm_addr,
  input wire logic [PHASE_W-1:0] phase,
  input wire logic               instr_valid,
  input wire seq_cmd_t           cmd,
  input wire irq_t               irq,
  input wire irq_t               irq_ack,
  input wire logic               stack_full,
  input wire logic [6:0]         dm_addr,
  input wire logic               dm_wr,
  input wire logic [7:0]         dm_wdata,
  input wire logic               tab_low_wr
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  logic tk;
  logic pw;
  // executing last phase, and a low counter byte write
  assign tk = phase == PHASE_LAST && instr_valid;
  assign pw = dm_wr && dm_addr == PC_LOW_ADDR;
  a_phase_count: assert property (
    !$past(rst) |-> phase == $past(phase) + 2'h1)
    else $error("phase skipped");
  a_plain_next: assert property (
    tk && cmd.kind == CMD_NONE && !dm_wr && irq == 3'h0
    |=> pm_addr == $past(pm_addr) + 11'h1) else $error("no advance");
  a_jump_dummy: assert property (
    tk && cmd.kind == CMD_JUMP && !pw |=> pm_addr == $past(cmd.target)
    ##0 !instr_valid [*4] ##1 instr_valid) else $error("jump");
  a_skip_dummy: assert property (
    tk && cmd.kind == CMD_SKIP && !pw |=> pm_addr == $past(pm_addr) + 11'h1
    ##0 !instr_valid [*4] ##1 instr_valid) else $error("skip");
  a_irq_ext: assert property (
    tk && cmd.kind == CMD_NONE && !dm_wr && irq.ext && !stack_full
    |=> irq_ack.ext && pm_addr == VEC_EXT) else $error("ext vector");
  a_irq_full: assert property (
    tk && stack_full |=> irq_ack == 3'h0) else $error("ack when full");
  a_table_two: assert property (
    tk && (cmd.kind == CMD_TAB_CUR || cmd.kind == CMD_TAB_LAST) && !pw
    |=> !instr_valid [*4] ##1 instr_valid && tab_low_wr) else $error("table");
  a_table_last: assert property (
    tk && cmd.kind == CMD_TAB_LAST && !pw |=> pm_addr >> 8 == 11'h7)
    else $error("last page");
  a_pcl_jump: assert property (
    tk && pw |=> pm_addr[7:0] == $past(dm_wdata)
    && pm_addr >> 8 == $past(pm_addr) >> 8) else $error("short jump");
  a_reset_zero: assert property (
    $past(rst) |-> pm_addr == PC_RESET) else $error("reset address");
endmodule : seq_sva
bind program_sequencer_table_read seq_sva i_seq_sva (
  .clk_sys, .rst, .pm_addr, .phase, .instr_valid, .cmd, .irq, .irq_ack,
  .stack_full, .dm_addr, .dm_wr, .dm_wdata, .tab_low_wr);
`default_nettype wire

// File: bench/seq_partner.sv
// program memory and latched interrupt sources
`timescale 1ns/10ps
`default_nettype none
module seq_partner
  import seq_pkg::*;
(
  input  wire logic [PC_W-1:0]   pm_addr,
  output logic      [WORD_W-1:0] pm_data,
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire irq_t              irq_set,
  input  wire irq_t              irq_ack,
  output irq_t                   irq
);
  // memory word is a scrambled copy of its address
  assign pm_data = {pm_addr[2:0], pm_addr} ^ 14'h1a6b;
  // a request stays up until it is acknowledged
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq <= irq_t'(3'h0);
    end else begin
      irq <= irq_t'((irq & ~irq_ack) | irq_set);
    end
  end
endmodule : seq_partner
`default_nettype wire

// File: bench/program_sequencer_table_read_tb_top.sv
// self-checking bench for the program sequencer
`timescale 1ns/10ps
`default_nettype none
module program_sequencer_table_read_tb_top
  import seq_pkg::*;
;
  logic              clk_sys, rst, stack_full, dm_wr, push, pop;
  logic              instr_valid, tab_low_wr, w;
  logic [PC_W-1:0]   pm_addr, stack_top, push_addr;
  logic [WORD_W-1:0] pm_data, instr;
  logic [PHASE_W-1:0] phase;
  logic [6:0]        dm_addr;
  logic [7:0]        dm_wdata, dm_rdata, tab_low;
  seq_cmd_t          cmd;
  cmd_kind_t         k;
  irq_t              irq, irq_ack, irq_set;
  int bad_count, compares, cyc, last, seed, epc, tptr, thigh, elow, eg, epush;
  int eack;

  program_sequencer_table_read i_program_sequencer_table_read (.clk_sys,
    .rst, .pm_addr, .pm_data, .phase, .instr, .instr_valid, .cmd,
    .stack_top, .stack_full, .push, .pop, .push_addr, .irq, .irq_ack,
    .dm_addr, .dm_wr, .dm_wdata, .dm_rdata, .tab_low, .tab_low_wr);
  seq_partner i_seq_partner (.clk_sys, .rst, .pm_addr, .pm_data, .irq_set,
    .irq_ack, .irq);

  function automatic int rom(int a);
    return {a[2:0], a[10:0]} ^ 14'h1a6b;
  endfunction : rom

  task automatic chk(logic [15:0] seen, int exp);
    compares++;
    if (seen !== 16'(exp)) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, 16'(exp));
    end
  endtask : chk

  task automatic results();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  // check the executing word, then hand over one command
  task automatic exec(int t, int a, int d);
    int nx;
    int ta;
    dm_addr = 7'(a);
    repeat (12) begin
      if (phase != PHASE_LAST || instr_valid !== 1'b1) begin
        @(posedge clk_sys);
        #1;
      end
    end
    chk(instr, rom(epc));
    if (last > 0) chk(16'(cyc - last), eg);
    chk(dm_rdata, (a == 6) ? ((epc + 1) & 'hff) : (a == 7) ? tptr :
        (a == 8) ? thigh : 0);
    last = cyc;
    cmd = '{k, 11'(t)};
    dm_wr = w;
    dm_wdata = 8'(d);
    stack_top = 11'($random(seed));
    stack_full = ($random(seed) & 3) == 0;
    nx = epc + 1;
    eg = 8;
    eack = 0;
    epush = epc + 1;
    ta = ((k == CMD_TAB_LAST) ? 'h700 : ((epc + 1) & 'h700)) | tptr;
    if (w && a == 6) nx = ((epc + 1) & 'h700) | d;
    else if (k == CMD_JUMP || k == CMD_CALL) nx = t;
    else if (k == CMD_RET) nx = stack_top;
    else if (k == CMD_SKIP) nx = epc + 2;
    else if (k != CMD_NONE) begin
      elow = rom(ta) & 'hff;
      thigh = rom(ta) >> 8;
    end else if (irq != 3'h0 && !stack_full) begin
      nx = irq.ext ? VEC_EXT : irq.timer ? VEC_TIMER : VEC_ADC;
      eack = irq.ext ? 4 : irq.timer ? 2 : 1;
    end else eg = 4;
    if (w && a == 7) tptr = d;
    epc = nx & 'h7ff;
    @(posedge clk_sys);
    #1;
    chk(pop, k == CMD_RET);
    chk(push, k == CMD_CALL || eack != 0);
    chk(irq_ack, eack);
    cmd.kind = CMD_NONE;
    dm_wr = 1'b0;
  endtask : exec

  // pulses checked in the clock they stand
  always @(negedge clk_sys) begin
    if (tab_low_wr === 1'b1) chk(tab_low, elow);
    if (push === 1'b1) chk(push_addr, epush);
  end

  always @(posedge clk_sys) cyc <= cyc + 1;

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // hang guard
  initial begin
    #40000;
    bad_count++;
    results();
  end

  // reset, then alternate plain instructions with each of the seven command kinds in turn
  initial begin
    seed = 32'h0ecf4171;
    rst = 1'b1;
    cmd = '{CMD_NONE, 11'h0};
    dm_addr = 7'h0;
    dm_wr = 1'b0;
    dm_wdata = 8'h0;
    stack_top = 11'h0;
    stack_full = 1'b0;
    irq_set = irq_t'(3'h0);
    repeat (20) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    for (int i = 0; i < 200; i++) begin
      irq_set = irq_t'(3'($random(seed) & $random(seed) & $random(seed)));
      @(posedge clk_sys);
      #1;
      irq_set = irq_t'(3'h0);
      k = (i % 2) ? cmd_kind_t'(3'((i / 2) % 7)) : CMD_NONE;
      w = (k == CMD_NONE) && (($random(seed) & 1) == 1);
      exec($random(seed) & 'h7ff, 5 + ($random(seed) & 3),
           $random(seed) & 'hff);
    end
    results();
  end
endmodule : program_sequencer_table_read_tb_top
`default_nettype wire
